// *** src/halfword_instr_decoder.sv ***
// Front-end decoder that splits an aligned halfword stream into short and
// long instructions, classes short ones and resolves special specifiers.
// Assumes fetch and the execute stage run on clk and handshake by valid.
`timescale 1ns/1ns

// Contract
// - Stream is aligned halfwords; long is two consecutive, short is one.
// - Top five bits 11101, 11110 or 11111 start a long instruction.
// - Undefined encodings raise an undefined flag instead of executing.
// - Fixed bits holding the wrong value may be flagged unpredictable.
// - Omitted extension instructions are undefined for this generation.
// - Specifier fifteen as source reads instruction address plus four.
// - Literal reads of fifteen give address plus four, word aligned.
// - Word load to specifier fifteen branches; loaded bit zero must be one.
// - Narrow loads to specifier fifteen become memory hints.
// - Coprocessor transfer to fifteen writes top four bits into flags.
// - Special cases read fifteen as zero or discard the result write.
// - Stack pointer low two bits read zero; software must not set them.
// - Long forms support stack pointer as base, operand, transfer, address.
// - Top six bits 00xxxx, 010000, 010001 select first three classes.
// - 01001x is literal load; 0101xx, 011xxx, 100xxx single load/store.
// - 10100x pc address, 10101x sp address, 1011xx miscellaneous.
// - 11000x store many, 11001x load many, 1101xx and 11100x branches.
module halfword_instr_decoder #(
    parameter bit EXT_PRESENT = 1'b1
) (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          in_valid,
    input  wire logic [15:0]                   in_half,
    input  wire logic [31:0]                   in_addr,
    input  wire logic                          in_ext_op,
    input  wire logic                          flush,
    input  wire logic [3:0]                    src_spec,
    input  wire logic                          src_literal,
    input  wire logic                          src_zero_case,
    input  wire logic                          dst_discard_case,
    input  wire logic                          word_load_dst,
    input  wire logic                          narrow_load_dst,
    input  wire logic                          coproc_to_core_transfer,
    input  wire logic [31:0]                   load_data,
    input  wire logic [31:0]                   coproc_data,
    input  wire logic [31:0]                   stack_pointer_in,
    input  wire logic [31:0]                   src_reg_data,
    output logic                               out_valid,
    output logic                               out_is_long,
    output hw_dec_pkg::instr_class_e           out_class,
    output logic                               out_undef,
    output logic                               out_unpred,
    output logic [31:0]                        out_instr,
    output logic [31:0]                        operand_val,
    output logic                               write_suppress,
    output logic                               branch_taken,
    output logic [31:0]                        branch_target,
    output logic                               branch_state_err,
    output logic                               mem_hint,
    output logic                               flags_we,
    output logic [3:0]                         app_status_flags,
    output logic [31:0]                        stack_pointer_reg
);

    // The operand and branch paths are sized for 32-bit addresses only.
    if (hw_dec_pkg::ADDR_W != 32) begin : g_addr_check
        $error("halfword_instr_decoder serves 32-bit addresses only");
    end

    hw_dec_pkg::half_state_e  state_r;
    logic [15:0]              first_half_r;
    hw_dec_pkg::instr_class_e sc_cls;
    logic                     sc_undef;
    logic                     sc_unpred;
    logic                     is_prefix;
    logic [31:0]              pc_read;

    short_class_dec u_short (
        .half   (in_half),
        .cls    (sc_cls),
        .undef  (sc_undef),
        .unpred (sc_unpred)
    );

    function automatic logic long_prefix(input logic [15:0] h);
        logic [4:0] t;
        t = h[15:11];
        long_prefix = (t == hw_dec_pkg::LONG_PFX_A) ||
                      (t == hw_dec_pkg::LONG_PFX_B) ||
                      (t == hw_dec_pkg::LONG_PFX_C);
    endfunction

    assign is_prefix = long_prefix(in_half);
    assign pc_read   = in_addr + hw_dec_pkg::PC_READ_OFS;

    // Halfword pairing: a prefix waits for its partner before anything is
    // issued, so execute never sees half an instruction.
    always_ff @(posedge clk) begin
        if (!rst_n || flush) begin
            state_r      <= hw_dec_pkg::ST_FIRST;
            first_half_r <= 16'h0000;
        end else if (in_valid) begin
            case (state_r)
                hw_dec_pkg::ST_FIRST: begin
                    if (is_prefix) begin
                        state_r      <= hw_dec_pkg::ST_SECOND;
                        first_half_r <= in_half;
                    end
                end
                hw_dec_pkg::ST_SECOND: begin
                    state_r <= hw_dec_pkg::ST_FIRST;
                end
                default: state_r <= hw_dec_pkg::ST_FIRST;
            endcase
        end
    end

    // Decoded instruction presentation.
    always_ff @(posedge clk) begin
        if (!rst_n || flush) begin
            out_valid   <= 1'b0;
            out_is_long <= 1'b0;
            out_class   <= hw_dec_pkg::CLS_NONE;
            out_undef   <= 1'b0;
            out_unpred  <= 1'b0;
            out_instr   <= 32'h0000_0000;
        end else begin
            out_valid   <= 1'b0;
            out_undef   <= 1'b0;
            out_unpred  <= 1'b0;
            if (in_valid && state_r == hw_dec_pkg::ST_SECOND) begin
                out_valid   <= 1'b1;
                out_is_long <= 1'b1;
                out_class   <= hw_dec_pkg::CLS_LONG;
                out_instr   <= {first_half_r, in_half};
                // Long extension ops without the extension are undefined.
                out_undef   <= in_ext_op && !EXT_PRESENT;
            end else if (in_valid && !is_prefix) begin
                out_valid   <= 1'b1;
                out_is_long <= 1'b0;
                out_class   <= sc_cls;
                out_instr   <= {16'h0000, in_half};
                out_undef   <= sc_undef ||
                               (in_ext_op && !EXT_PRESENT);
                out_unpred  <= sc_unpred;
            end
        end
    end

    // Operand value for a source specifier.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            operand_val    <= 32'h0000_0000;
            write_suppress <= 1'b0;
        end else begin
            write_suppress <= dst_discard_case;
            if (src_spec == hw_dec_pkg::SPEC_PC && src_zero_case) begin
                operand_val <= 32'h0000_0000;
            end else if (src_spec == hw_dec_pkg::SPEC_PC && src_literal) begin
                operand_val <= pc_read & hw_dec_pkg::WORD_ALIGN_MASK;
            end else if (src_spec == hw_dec_pkg::SPEC_PC) begin
                operand_val <= pc_read;
            end else if (src_spec == hw_dec_pkg::SPEC_SP) begin
                // Stack pointer usable as base or first operand.
                operand_val <= stack_pointer_in
                             & hw_dec_pkg::WORD_ALIGN_MASK;
            end else begin
                operand_val <= src_reg_data;
            end
        end
    end

    // Writes to specifier fifteen.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            branch_taken     <= 1'b0;
            branch_target    <= 32'h0000_0000;
            branch_state_err <= 1'b0;
            mem_hint         <= 1'b0;
        end else begin
            branch_taken     <= word_load_dst;
            branch_target    <= {load_data[31:1], 1'b0};
            // Bit zero clear would select an unsupported state.
            branch_state_err <= word_load_dst && !load_data[0];
            mem_hint         <= narrow_load_dst;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags_we         <= 1'b0;
            app_status_flags <= 4'h0;
        end else begin
            flags_we <= coproc_to_core_transfer;
            if (coproc_to_core_transfer) begin
                app_status_flags <= coproc_data[31:28];
            end
        end
    end

    // Low two bits always read zero whatever software wrote.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stack_pointer_reg <= 32'h0000_0000;
        end else begin
            stack_pointer_reg <= stack_pointer_in
                               & hw_dec_pkg::WORD_ALIGN_MASK;
        end
    end

endmodule // halfword_instr_decoder

// *** src/hw_dec_pkg.sv ***
// Package of constants and class codes for the halfword instruction decoder.
// Assumes a 32-bit address space and halfword-aligned fetch addresses.
package hw_dec_pkg;

    localparam int ADDR_W = 32;
    localparam int HALF_W = 16;

    // Top five bits that mark the first half of a long instruction.
    localparam logic [4:0] LONG_PFX_A = 5'h1d;
    localparam logic [4:0] LONG_PFX_B = 5'h1e;
    localparam logic [4:0] LONG_PFX_C = 5'h1f;

    localparam logic [3:0] SPEC_PC = 4'hf;
    localparam logic [3:0] SPEC_SP = 4'hd;
    localparam logic [ADDR_W-1:0] PC_READ_OFS = 32'h0000_0004;
    localparam logic [ADDR_W-1:0] WORD_ALIGN_MASK = 32'hffff_fffc;

    localparam logic [5:0] OPC_DATA_PROC = 6'h10;
    localparam logic [5:0] OPC_SPECIAL   = 6'h11;
    localparam logic [3:0] SPECIAL_UNPRED = 4'h4;
    localparam logic [3:0] SPECIAL_RSVD_A = 4'h6;
    localparam logic [3:0] SPECIAL_RSVD_B = 4'h7;

    localparam logic [6:0] MISC_STATE_CHG = 7'h33;

    localparam logic [3:0] CLS_RESET = 4'h0;

    typedef enum logic [3:0] {
        CLS_SHIFT_ADD_MOV = 4'h0,
        CLS_DATA_PROC     = 4'h1,
        CLS_SPECIAL_BX    = 4'h2,
        CLS_LIT_LOAD      = 4'h3,
        CLS_LOAD_STORE    = 4'h4,
        CLS_PC_ADDR       = 4'h5,
        CLS_SP_ADDR       = 4'h6,
        CLS_MISC          = 4'h7,
        CLS_STORE_MULTI   = 4'h8,
        CLS_LOAD_MULTI    = 4'h9,
        CLS_COND_BR_SVC   = 4'ha,
        CLS_UNCOND_BR     = 4'hb,
        CLS_LONG          = 4'hc,
        CLS_NONE          = 4'hf
    } instr_class_e;

    typedef enum logic [0:0] {
        ST_FIRST  = 1'b0,
        ST_SECOND = 1'b1
    } half_state_e;

endpackage

// *** src/short_class_dec.sv ***
// Combinational classer of a short instruction by its top bits.
// Assumes the caller has already ruled out the long-instruction prefixes.
`timescale 1ns/1ns
module short_class_dec (
    input  wire logic [15:0]               half,
    output hw_dec_pkg::instr_class_e       cls,
    output logic                           undef,
    output logic                           unpred
);

    logic [5:0] top;
    logic [6:0] misc_op;
    logic [3:0] spec_op;

    assign top     = half[15:10];
    assign misc_op = half[11:5];
    assign spec_op = half[9:6];

    always_comb begin
        cls    = hw_dec_pkg::CLS_NONE;
        undef  = 1'b0;
        unpred = 1'b0;
        casez (top)
            6'b00????: cls = hw_dec_pkg::CLS_SHIFT_ADD_MOV;
            6'b010000: cls = hw_dec_pkg::CLS_DATA_PROC;
            6'b010001: begin
                cls = hw_dec_pkg::CLS_SPECIAL_BX;
                if (spec_op == hw_dec_pkg::SPECIAL_UNPRED) begin
                    unpred = 1'b1;
                end
                if (spec_op == hw_dec_pkg::SPECIAL_RSVD_A ||
                    spec_op == hw_dec_pkg::SPECIAL_RSVD_B) begin
                    unpred = 1'b1;
                end
            end
            6'b01001?: cls = hw_dec_pkg::CLS_LIT_LOAD;
            6'b0101??,
            6'b011???,
            6'b100???: cls = hw_dec_pkg::CLS_LOAD_STORE;
            6'b10100?: cls = hw_dec_pkg::CLS_PC_ADDR;
            6'b10101?: cls = hw_dec_pkg::CLS_SP_ADDR;
            6'b1011??: begin
                cls = hw_dec_pkg::CLS_MISC;
                casez (misc_op)
                    7'b0110011, 7'b00000??, 7'b00001??, 7'b0001???,
                    7'b001000?, 7'b001001?, 7'b001010?, 7'b001011?,
                    7'b0011???, 7'b010????, 7'b1001???, 7'b101000?,
                    7'b101001?, 7'b101011?, 7'b1011???, 7'b110????,
                    7'b1110???, 7'b1111???: undef = 1'b0;
                    default: undef = 1'b1;
                endcase
            end
            6'b11000?: cls = hw_dec_pkg::CLS_STORE_MULTI;
            6'b11001?: cls = hw_dec_pkg::CLS_LOAD_MULTI;
            6'b1101??: cls = hw_dec_pkg::CLS_COND_BR_SVC;
            6'b11100?: cls = hw_dec_pkg::CLS_UNCOND_BR;
            default: begin
                cls   = hw_dec_pkg::CLS_NONE;
                undef = 1'b1;
            end
        endcase
    end

endmodule // short_class_dec

// *** verif/fetch_model.sv ***
// Fetch-side model offering aligned halfwords to the decoder.
// Assumes the decoder samples on the rising edge of clk.
`timescale 1ns/1ns
module fetch_model (
    input  wire logic   clk,
    output logic        in_valid,
    output logic [15:0] in_half,
    output logic [31:0] in_addr
);
    initial begin
        in_valid = 1'b0;
        in_half  = 16'h0000;
        in_addr  = 32'h0000_0000;
    end
    // The halfword stays up until the next call, so calls run back to back.
    task automatic send(input logic [15:0] h, input logic [31:0] a);
        @(negedge clk);
        in_valid = 1'b1;
        in_half  = h;
        in_addr  = {a[31:1], 1'b0};
    endtask
    // Idle data is inverted so a stale halfword never passes for fresh.
    task automatic idle();
        @(negedge clk);
        in_valid = 1'b0;
        in_half  = ~in_half;
    endtask
endmodule // fetch_model

// *** verif/hw_dec_chk.sv ***
// Port checker for the halfword decoder.
// Assumes it is bound to halfword_instr_decoder.
`timescale 1ns/1ns
module hw_dec_chk (
    input wire logic                     clk,
    input wire logic                     rst_n,
    input wire logic                     in_valid,
    input wire logic [15:0]              in_half,
    input wire logic [31:0]              in_addr,
    input wire logic                     flush,
    input wire logic [3:0]               src_spec,
    input wire logic                     src_literal,
    input wire logic                     src_zero_case,
    input wire logic                     out_valid,
    input wire logic                     out_is_long,
    input wire hw_dec_pkg::instr_class_e out_class,
    input wire logic [31:0]              out_instr,
    input wire logic [31:0]              operand_val
);
    logic        pend_r;
    logic [15:0] first_r;
    logic        pfx;
    logic        sh;
    logic        pc;
    assign pfx = in_half[15:11] >= hw_dec_pkg::LONG_PFX_A;
    assign sh  = in_valid && !flush && !pend_r && !pfx;
    assign pc  = src_spec == hw_dec_pkg::SPEC_PC;
    always_ff @(posedge clk) begin
        if (!rst_n || flush) begin
            pend_r <= 1'b0;
        end else if (in_valid) begin
            pend_r <= !pend_r && pfx;
        end
    end
    always_ff @(posedge clk) begin
        if (in_valid) begin
            first_r <= in_half;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_short; sh |=> out_valid && !out_is_long
        && out_instr == {16'h0000, $past(in_half)}; endproperty
    a_short: assert property (p_short) else $error("short miss");
    property p_pfx; in_valid && !flush && !pend_r && pfx |=> !out_valid;
    endproperty
    a_pfx: assert property (p_pfx) else $error("prefix answered");
    property p_long; in_valid && !flush && pend_r |=> out_valid
        && out_is_long && out_class == hw_dec_pkg::CLS_LONG
        && out_instr == {$past(first_r), $past(in_half)}; endproperty
    a_long: assert property (p_long) else $error("long miss");
    property p_dp; sh && in_half[15:10] == hw_dec_pkg::OPC_DATA_PROC
        |=> out_class == hw_dec_pkg::CLS_DATA_PROC; endproperty
    a_dp: assert property (p_dp) else $error("dp class");
    property p_ls; sh && (in_half[15:12] == 4'h5 || in_half[15:13]
        inside {3'h3, 3'h4}) |=> out_class == hw_dec_pkg::CLS_LOAD_STORE;
    endproperty
    a_ls: assert property (p_ls) else $error("ls class");
    property p_pc; pc && !src_literal && !src_zero_case
        |=> operand_val == $past(in_addr) + 32'h0000_0004; endproperty
    a_pc: assert property (p_pc) else $error("pc read");
    property p_lit; pc && src_literal && !src_zero_case |=> operand_val
        == (($past(in_addr) + 32'h0000_0004) & 32'hffff_fffc); endproperty
    a_lit: assert property (p_lit) else $error("literal read");
    property p_zero; pc && src_zero_case |=> operand_val == 32'h0000_0000;
    endproperty
    a_zero: assert property (p_zero) else $error("zero read");
endmodule // hw_dec_chk
bind halfword_instr_decoder hw_dec_chk hw_dec_chk_i (.clk, .rst_n,
    .in_valid, .in_half, .in_addr, .flush, .src_spec, .src_literal,
    .src_zero_case, .out_valid, .out_is_long, .out_class, .out_instr,
    .operand_val);

// *** verif/tb.sv ***
// Self-checking bench for the halfword decoder.
// Assumes the fetch model drives the stream and the checker is bound.
`timescale 1ns/1ns
module tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        in_valid;
    logic [15:0] in_half;
    logic [31:0] in_addr;
    logic        in_ext_op = 1'b0;
    logic        flush = 1'b0;
    logic [3:0]  src_spec = 4'h0;
    logic        src_literal = 1'b0;
    logic        src_zero_case = 1'b0;
    logic        dst_discard_case = 1'b0;
    logic        word_load_dst = 1'b0;
    logic        narrow_load_dst = 1'b0;
    logic        coproc_to_core_transfer = 1'b0;
    logic [31:0] load_data = 32'h0000_0000;
    logic [31:0] coproc_data = 32'h0000_0000;
    logic [31:0] stack_pointer_in = 32'h0000_0000;
    logic [31:0] src_reg_data = 32'h0000_0000;
    logic        out_valid, out_is_long, out_undef, out_unpred, mem_hint;
    logic        write_suppress, branch_taken, branch_state_err, flags_we;
    logic [3:0]  app_status_flags;
    logic [31:0] out_instr, operand_val, branch_target, stack_pointer_reg;
    hw_dec_pkg::instr_class_e out_class;
    int          failures = 0;
    int          samples_checked = 0;
    // Extensions are left out so that extension opcodes must be refused.
    halfword_instr_decoder #(.EXT_PRESENT(1'b0)) halfword_instr_decoder_i (
        .clk, .rst_n, .in_valid, .in_half, .in_addr, .in_ext_op, .flush,
        .src_spec, .src_literal, .src_zero_case, .dst_discard_case,
        .word_load_dst, .narrow_load_dst, .coproc_to_core_transfer,
        .load_data, .coproc_data, .stack_pointer_in, .src_reg_data,
        .out_valid, .out_is_long, .out_class, .out_undef, .out_unpred,
        .out_instr, .operand_val, .write_suppress, .branch_taken,
        .branch_target, .branch_state_err, .mem_hint, .flags_we,
        .app_status_flags, .stack_pointer_reg);
    fetch_model fetch_model_i (.clk, .in_valid, .in_half, .in_addr);
    always #4 clk = ~clk;
    task automatic check(input string nm, input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checked %0d failed %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic one(input logic [15:0] h);
        fetch_model_i.send(h, 32'h0000_1002);
        fetch_model_i.idle();
    endtask
    task automatic dec(input logic lg, input logic [3:0] c,
                       input logic [31:0] ins);
        check("out_valid", out_valid, 32'h1);
        check("out_is_long", out_is_long, lg);
        check("out_class", out_class, c);
        check("out_instr", out_instr, ins);
    endtask
    task automatic t_classes();
        logic [15:0] hv [14] = '{16'h0000, 16'h4000, 16'h4400, 16'h4800,
            16'h5000, 16'h6000, 16'h8000, 16'ha000, 16'ha800, 16'hb000,
            16'hc000, 16'hc800, 16'hd000, 16'he000};
        logic [3:0] cv [14] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h4, 4'h4,
            4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb};
        for (int i = 0; i < 14; i++) begin
            one(hv[i]);
            dec(1'b0, cv[i], {16'h0000, hv[i]});
            check("out_undef", out_undef, 32'h0);
        end
        $display("t_classes done");
    endtask
    task automatic t_long();
        logic [15:0] pv [3] = '{16'he800, 16'hf000, 16'hf800};
        for (int i = 0; i < 3; i++) begin
            one(pv[i]);
            check("out_valid", out_valid, 32'h0);
            fetch_model_i.send(16'hf800, 32'h0000_1002);
            fetch_model_i.send(16'h2001, 32'h0000_1006);
            dec(1'b1, hw_dec_pkg::CLS_LONG, {pv[i], 16'hf800});
            fetch_model_i.idle();
            dec(1'b0, 4'h0, 32'h0000_2001);
        end
        one(16'hf000);
        flush = 1'b1;
        @(negedge clk);
        flush = 1'b0;
        one(16'h2001);
        dec(1'b0, 4'h0, 32'h0000_2001);
        $display("t_long done");
    endtask
    task automatic t_undef();
        in_ext_op = 1'b1;
        one(16'h2001);
        in_ext_op = 1'b0;
        check("out_undef", out_undef, 32'h1);
        in_ext_op = 1'b1;
        fetch_model_i.send(16'hf000, 32'h0000_1002);
        one(16'h8000);
        in_ext_op = 1'b0;
        check("out_is_long", out_is_long, 32'h1);
        check("out_undef", out_undef, 32'h1);
        one(16'hb700);
        check("out_undef", out_undef, 32'h1);
        one(16'h4500);
        check("out_unpred", out_unpred, 32'h1);
        $display("t_undef done");
    endtask
    task automatic t_operand();
        src_spec = hw_dec_pkg::SPEC_PC;
        @(negedge clk);
        check("operand_val", operand_val, 32'h0000_1006);
        src_literal = 1'b1;
        @(negedge clk);
        check("operand_val", operand_val, 32'h0000_1004);
        src_zero_case = 1'b1;
        @(negedge clk);
        check("operand_val", operand_val, 32'h0000_0000);
        src_spec = hw_dec_pkg::SPEC_SP;
        stack_pointer_in = 32'h0000_3007;
        @(negedge clk);
        check("stack_pointer_reg", stack_pointer_reg, 32'h0000_3004);
        check("operand_val", operand_val, 32'h0000_3004);
        stack_pointer_in = 32'h0000_3010;
        @(negedge clk);
        check("operand_val", operand_val, 32'h0000_3010);
        check("stack_pointer_reg", stack_pointer_reg, 32'h0000_3010);
        $display("t_operand done");
    endtask
    task automatic t_side();
        load_data = 32'h0000_2001;
        coproc_data = 32'ha555_1234;
        word_load_dst = 1'b1;
        coproc_to_core_transfer = 1'b1;
        dst_discard_case = 1'b1;
        @(negedge clk);
        check("branch_taken", branch_taken, 32'h1);
        check("branch_target", branch_target, 32'h0000_2000);
        check("branch_state_err", branch_state_err, 32'h0);
        check("flags_we", flags_we, 32'h1);
        check("app_status_flags", app_status_flags, 32'ha);
        check("write_suppress", write_suppress, 32'h1);
        load_data = 32'h0000_2000;
        narrow_load_dst = 1'b1;
        coproc_to_core_transfer = 1'b0;
        dst_discard_case = 1'b0;
        @(negedge clk);
        word_load_dst = 1'b0;
        narrow_load_dst = 1'b0;
        check("branch_state_err", branch_state_err, 32'h1);
        check("mem_hint", mem_hint, 32'h1);
        $display("t_side done");
    endtask
    initial begin
        repeat (3) @(negedge clk);
        check("out_class", out_class, hw_dec_pkg::CLS_NONE);
        rst_n = 1'b1;
        t_classes();
        t_long();
        t_undef();
        t_operand();
        t_side();
        close_out();
    end
    initial begin
        repeat (3000) @(posedge clk);
        failures++;
        close_out();
    end
endmodule // tb
